// [chs_host.sv]
/*
 * host-side controller that drives a removable flash card through its
 * strobe, attribute select and ready/busy pins in three modes.
 * assumes pins come from outside the clock domain; the card data bus
 * is three signals (in, out, enable) resolved by the surroundings.
 */
`timescale 1ns/1ns
`include "chs_cfg.svh"
module chs_host
    import chs_pkg::*;
#(
    parameter int DATA_W = `CHS_DATA_W,
    parameter int ADDR_W = `CHS_ADDR_W
) (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               clk_en,
    // user request side
    input  wire logic               req_valid,
    input  wire logic               req_write,
    input  wire logic               req_attr,
    input  wire logic [ADDR_W-1:0]  req_addr,
    input  wire logic [DATA_W-1:0]  req_wdata,
    input  wire chs_pkg::chs_mode_type mode_sel,
    output logic                    req_ready,
    output logic                    rsp_valid,
    output logic      [DATA_W-1:0]  rsp_rdata,
    output logic                    card_ready,
    output logic                    irq_event,
    output logic      [1:0]         irq_last,
    // card pins
    output logic      [ADDR_W-1:0]  card_addr,
    output logic                    io_write_strobe_n,
    output logic                    io_read_strobe_n,
    output logic                    write_enable_n,
    output logic                    output_enable_n,
    output logic                    attr_select_n,
    output logic                    card_reset,
    input  wire logic [DATA_W-1:0]  card_data_in,
    output logic      [DATA_W-1:0]  card_data_out,
    output logic                    card_data_oe,
    input  wire logic               ready_busy_pin
);
    // ==========================================================
    // pin synchronisers
    logic rb_meta, rb_sync, rb_prev;
    logic [DATA_W-1:0] dat_meta, dat_sync;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rb_meta  <= 1'b0;
            rb_sync  <= 1'b0;
            rb_prev  <= 1'b0;
            dat_meta <= '0;
            dat_sync <= '0;
        end else if (clk_en) begin
            rb_meta  <= ready_busy_pin;
            rb_sync  <= rb_meta;
            rb_prev  <= rb_sync;
            dat_meta <= card_data_in;
            dat_sync <= dat_meta;
        end
    end

    // ==========================================================
    // pin meaning per mode
    function automatic logic card_is_ready(input chs_mode_type m, input logic rb);
        // pull-up idles the pin high; io and ide use it for interrupts
        card_is_ready = (m == chs_mem_type_mode_mem) ? rb : 1'b1;
    endfunction
    function automatic logic irq_active(input chs_mode_type m, input logic rb);
        if (m == chs_mem_type_mode_io) begin
            irq_active = ~rb;
        end else if (m == chs_mem_type_mode_ide) begin
            irq_active = rb;
        end else begin
            irq_active = 1'b0;
        end
    endfunction

    // ==========================================================
    // access sequencer
    chs_state_type state;
    chs_mode_type  cur_mode;
    logic          cur_write;
    logic          cur_attr;
    logic [3:0]    cnt;
    logic          init_done;
    // in memory mode, wait after reset for ready to rise; io and ide go straight to idle
    // no access while busy in init
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state             <= chs_wait_ready;
            cur_mode          <= chs_mem_type_mode_mem;
            cur_write         <= 1'b0;
            cur_attr          <= 1'b0;
            cnt               <= 4'h0;
            init_done         <= 1'b0;
            req_ready         <= 1'b0;
            rsp_valid         <= 1'b0;
            rsp_rdata         <= '0;
            card_addr         <= '0;
            io_write_strobe_n <= 1'b1;
            io_read_strobe_n  <= 1'b1;
            write_enable_n    <= 1'b1;
            output_enable_n   <= 1'b1;
            attr_select_n     <= 1'b1;
            card_data_out     <= '0;
            card_data_oe      <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            case (state)
                chs_wait_ready: begin
                    // memory mode waits for ready high
                    if (card_is_ready(mode_sel, rb_sync) || init_done) begin
                        init_done <= 1'b1;
                        state     <= chs_idle;
                        req_ready <= 1'b1;
                    end
                end
                chs_idle: begin
                    // ide select rides on the output enable pin
                    output_enable_n <= (mode_sel != chs_mem_type_mode_ide);
                    attr_select_n   <= (mode_sel == chs_mem_type_mode_ide) ? 1'b1 : attr_select_n;
                    if (req_valid) begin
                        req_ready <= 1'b0;
                        cur_mode  <= mode_sel;
                        cur_write <= req_write;
                        cur_attr  <= req_attr;
                        card_addr <= req_addr;
                        if (mode_sel == chs_mem_type_mode_ide) begin
                            attr_select_n <= 1'b1;
                        end else if (mode_sel == chs_mem_type_mode_io) begin
                            attr_select_n <= 1'b0;
                        end else begin
                            attr_select_n <= ~req_attr;
                        end
                        card_data_out <= req_wdata;
                        card_data_oe  <= req_write;
                        cnt           <= 4'(`CHS_SETUP_CYC);
                        state         <= chs_setup;
                    end
                end
                chs_setup: begin
                    if (cnt > 4'h1) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        cnt   <= 4'(`CHS_STROBE_CYC);
                        state <= chs_strobe;
                        // io write not used in memory mode
                        // io mode output enable only for attribute space
                        // io reads via io read strobe
                        if (cur_mode == chs_mem_type_mode_mem) begin
                            write_enable_n  <= ~cur_write;
                            output_enable_n <= cur_write;
                        end else if (cur_mode == chs_mem_type_mode_io && cur_attr) begin
                            write_enable_n  <= ~cur_write;
                            output_enable_n <= cur_write;
                        end else begin
                            io_write_strobe_n <= ~cur_write;
                            io_read_strobe_n  <= cur_write;
                        end
                    end
                end
                chs_strobe: begin
                    if (cnt > 4'h1) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        // rising edge latches write data in card
                        io_write_strobe_n <= 1'b1;
                        io_read_strobe_n  <= 1'b1;
                        write_enable_n    <= 1'b1;
                        output_enable_n   <= (cur_mode != chs_mem_type_mode_ide);
                        rsp_rdata         <= cur_write ? '0 : dat_sync;
                        cnt               <= 4'(`CHS_HOLD_CYC);
                        state             <= chs_hold;
                    end
                end
                chs_hold: begin
                    if (cnt > 4'h1) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        card_data_oe <= 1'b0;
                        rsp_valid    <= 1'b1;
                        req_ready    <= 1'b1;
                        state        <= chs_idle;
                    end
                end
                default: begin
                    state <= chs_idle;
                end
            endcase
        end
    end

    // ==========================================================
    // ready and interrupt reporting
    logic [1:0] log_wr_addr;
    logic       irq_now;
    assign irq_now = irq_active(mode_sel, rb_sync) && !irq_active(mode_sel, rb_prev);
    always_ff @(posedge core_clk) begin
        if (reset) begin
            card_ready  <= 1'b0;
            irq_event   <= 1'b0;
            card_reset  <= 1'b1;
            log_wr_addr <= 2'h0;
        end else if (clk_en) begin
            // in memory mode a card held in reset shows busy, seen as not ready here; io and ide report ready
            card_ready  <= card_is_ready(mode_sel, rb_sync);
            irq_event   <= irq_now;
            card_reset  <= 1'b0;
            log_wr_addr <= irq_now ? log_wr_addr + 2'h1 : log_wr_addr;
        end
    end
    chs_irq_log #(
        .DEPTH (`CHS_IRQ_DEPTH),
        .WIDTH (2)
    ) u_log (
        .core_clk (core_clk),
        .clk_en   (clk_en),
        .wr_en    (irq_now),
        .wr_addr  (log_wr_addr),
        .wr_data  (mode_sel),
        .rd_addr  (log_wr_addr - 2'h1),
        .rd_data  (irq_last)
    );

    // ==========================================================
    // checks
    // no io write in memory mode
    a_no_io_write_strobe_n_mem: assert property (@(posedge core_clk) disable iff (reset)
        (state == chs_strobe && cur_mode == chs_mem_type_mode_mem) |-> io_write_strobe_n)
        else $error("io write pulsed in memory mode");
    // write data held across io write strobe rise
    a_wdata_hold: assert property (@(posedge core_clk) disable iff (reset)
        $rose(io_write_strobe_n) |-> card_data_oe)
        else $error("data released before strobe rise");
    a_oe_read: assert property (@(posedge core_clk) disable iff (reset)
        (state == chs_strobe && !output_enable_n && cur_mode != chs_mem_type_mode_ide)
        |-> !cur_write)
        else $error("output enable during write");
    a_attr_ide: assert property (@(posedge core_clk) disable iff (reset)
        (state == chs_strobe && cur_mode == chs_mem_type_mode_ide) |-> attr_select_n)
        else $error("attribute low in ide mode");
    // ide select held low in ide
    a_ide_select: assert property (@(posedge core_clk) disable iff (reset)
        (state == chs_strobe && cur_mode == chs_mem_type_mode_ide) |-> !output_enable_n)
        else $error("ide select released during access");
    a_attr_io: assert property (@(posedge core_clk) disable iff (reset)
        (!io_read_strobe_n || !io_write_strobe_n) && cur_mode == chs_mem_type_mode_io
        |-> !attr_select_n)
        else $error("attribute high in io cycle");
    a_strobe_len: assert property (@(posedge core_clk) disable iff (reset || !clk_en)
        $fell(io_read_strobe_n) |-> !io_read_strobe_n [*2])
        else $error("io read too short");
    a_init_block: assert property (@(posedge core_clk) disable iff (reset)
        !init_done |-> io_read_strobe_n && io_write_strobe_n && output_enable_n)
        else $error("access during init");
    a_ready_init: assert property (@(posedge core_clk) disable iff (reset)
        req_ready |-> init_done)
        else $error("ready before init");
    c_io_write: cover property (@(posedge core_clk) $rose(io_write_strobe_n));
    c_mem_read: cover property (@(posedge core_clk) $rose(output_enable_n));
    c_irq: cover property (@(posedge core_clk) irq_event);
endmodule

// [chs_cfg.svh]
/*
 * constants for the card host strobe controller.
 * assumes a 100 MHz core clock; included by the package and every module except the card model.
 */
`ifndef CHS_CFG_SVH
`define CHS_CFG_SVH
// ==========================================================
// timing
`define CHS_CLK_PERIOD_NS   10
`define CHS_SETUP_NS        30
`define CHS_SETUP_CYC       ((`CHS_SETUP_NS + `CHS_CLK_PERIOD_NS - 1) / `CHS_CLK_PERIOD_NS)
`define CHS_STROBE_NS       80
`define CHS_STROBE_CYC      ((`CHS_STROBE_NS + `CHS_CLK_PERIOD_NS - 1) / `CHS_CLK_PERIOD_NS)
`define CHS_HOLD_NS         30
`define CHS_HOLD_CYC        ((`CHS_HOLD_NS + `CHS_CLK_PERIOD_NS - 1) / `CHS_CLK_PERIOD_NS)
`define CHS_IRQ_DEPTH       4
`define CHS_DATA_W          16
`define CHS_ADDR_W          11
// mode codes on the mode_sel input
`define CHS_MODE_MEM        2'h0
`define CHS_MODE_IO         2'h1
`define CHS_MODE_IDE        2'h2
`endif

// [chs_pkg.sv]
/*
 * types for the card host strobe controller.
 * assumes chs_cfg.svh is on the include path.
 */
`include "chs_cfg.svh"
package chs_pkg;
    typedef enum logic [1:0] {
        chs_mem_type_mode_mem = `CHS_MODE_MEM,
        chs_mem_type_mode_io  = `CHS_MODE_IO,
        chs_mem_type_mode_ide = `CHS_MODE_IDE
    } chs_mode_type;
    typedef enum logic [2:0] {
        chs_idle, chs_setup, chs_strobe, chs_hold, chs_wait_ready
    } chs_state_type;
endpackage

// [chs_irq_log.sv]
/*
 * small memory that logs recent card interrupt events for the host.
 * assumes one clock; read data come out of a register.
 */
`timescale 1ns/1ns
`include "chs_cfg.svh"
module chs_irq_log #(
    parameter int DEPTH = `CHS_IRQ_DEPTH,
    parameter int WIDTH = 2
) (
    // clock
    input  wire logic                     core_clk,
    input  wire logic                     clk_en,
    // write side
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    // read side
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    always_ff @(posedge core_clk) begin
        if (clk_en && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// [chs_card_model.sv]
/*
 * behavioural flash card standing at the far side of chs_host.
 * assumes the bench hands it the mode and an interrupt command.
 */
`timescale 1ns/1ns
module chs_card_model
    import chs_pkg::*;
#(
    parameter int INIT_CYC = 20,
    parameter int BUSY_CYC = 5
) (
    // clock and mode
    input  wire logic                  core_clk,
    input  wire chs_pkg::chs_mode_type mode_sel,
    input  wire logic                  irq_cmd,
    // strobes from the host
    input  wire logic                  io_write_strobe_n,
    input  wire logic                  io_read_strobe_n,
    input  wire logic                  write_enable_n,
    input  wire logic                  output_enable_n,
    input  wire logic                  attr_select_n,
    input  wire logic                  card_reset,
    // address and data
    input  wire logic [10:0]           card_addr,
    input  wire logic [15:0]           card_data_out,
    output logic      [15:0]           card_data_in,
    output logic                       ready_busy_pin
);
    logic [15:0] cmn_mem [16];
    logic [15:0] attr_mem [16];
    logic [15:0] io_reg [16];
    logic [15:0] last = 16'h0000;
    logic [15:0] rd_val;
    logic        drive;
    logic        we_q;
    int          busy = 0;
    wire  [3:0]  a = card_addr[3:0];

    // ==========================================
    // writes
    // latch on trailing edge
    always @(posedge io_write_strobe_n)
        if (mode_sel != chs_mem_type_mode_mem)
            io_reg[a] <= card_data_out;
    always @(posedge write_enable_n)
        if (mode_sel == chs_mem_type_mode_mem && attr_select_n)
            cmn_mem[a] <= card_data_out;
        else if (mode_sel != chs_mem_type_mode_ide)
            attr_mem[a] <= card_data_out;

    // ==========================================
    // reads
    // drive while strobe low
    always_comb begin
        drive = 1'b0;
        rd_val = attr_mem[a];
        if (!io_read_strobe_n && mode_sel != chs_mem_type_mode_mem) begin
            drive = 1'b1;
            rd_val = io_reg[a];
        end else if (!output_enable_n && mode_sel != chs_mem_type_mode_ide) begin
            drive = 1'b1;
            if (mode_sel == chs_mem_type_mode_mem && attr_select_n)
                rd_val = cmn_mem[a];
        end
    end
    // released bus shows the inverse, so a stale read cannot pass
    assign card_data_in = drive ? rd_val : ~last;
    always @(posedge core_clk)
        if (drive)
            last <= rd_val;

    // ==========================================
    // ready, busy and interrupt pin
    // busy after reset and memory mode writes
    always @(posedge core_clk) begin
        we_q <= write_enable_n;
        if (card_reset)
            busy <= INIT_CYC;
        else if (write_enable_n && !we_q && mode_sel == chs_mem_type_mode_mem)
            busy <= BUSY_CYC;
        else if (busy > 0)
            busy <= busy - 1;
    end
    always_comb
        case (mode_sel)
            chs_mem_type_mode_mem: ready_busy_pin = (busy == 0);
            chs_mem_type_mode_io:  ready_busy_pin = !irq_cmd;
            default:               ready_busy_pin = irq_cmd;
        endcase
endmodule

// [tb.sv]
/*
 * self-checking bench for chs_host against a behavioural card.
 * assumes chs_cfg.svh on the include path; one 100 MHz clock.
 */
`timescale 1ns/1ns
`include "chs_cfg.svh"
module tb;
    import chs_pkg::*;
    localparam int INIT_CYC = 20;
    logic         core_clk = 1'b0;
    logic         reset = 1'b1;
    logic         clk_en = 1'b1;
    logic         req_valid = 1'b0;
    logic         req_write = 1'b0;
    logic         req_attr = 1'b0;
    logic         irq_cmd = 1'b0;
    logic         in_init = 1'b1;
    logic [10:0]  req_addr = 11'h000;
    logic [15:0]  req_wdata = 16'h0000;
    chs_mode_type mode_sel = chs_mem_type_mode_mem;
    chs_mode_type m;
    logic         req_ready, rsp_valid, card_ready, irq_event, io_write_strobe_n, a;
    logic         io_read_strobe_n, write_enable_n, output_enable_n, attr_select_n;
    logic         card_reset, card_data_oe, ready_busy_pin;
    logic [1:0]   irq_last;
    logic [3:0]   ad;
    logic [10:0]  card_addr;
    logic [15:0]  rsp_rdata, card_data_in, card_data_out, got, d, r;
    logic [15:0]  exp_mem [3][16];
    bit           seen [3][16];
    logic [31:0]  seed = 32'h0000_716a;
    int           n_errors = 0;
    int           n_checks = 0;
    int           k;

    chs_host dut (.*);
    chs_card_model #(.INIT_CYC(INIT_CYC), .BUSY_CYC(5)) card (.*);

    always #5 core_clk = ~core_clk;

    // ==========================================
    // helpers
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    // io space and ide share one register file
    function automatic int space(chs_mode_type mm, logic aa);
        if (mm == chs_mem_type_mode_ide)
            return 2;
        return aa ? 1 : ((mm == chs_mem_type_mode_mem) ? 0 : 2);
    endfunction
    task automatic check(string what, logic [15:0] e, logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic access(chs_mode_type mm, logic w, logic aa, logic [3:0] adr, logic [15:0] dd);
        mode_sel = mm;
        k = 0;
        while (req_ready !== 1'b1 && k < 300) begin
            @(negedge core_clk);
            k++;
        end
        req_valid = 1'b1;
        req_write = w;
        req_attr = aa;
        req_addr = {7'h00, adr};
        req_wdata = dd;
        @(negedge core_clk);
        req_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 40) begin
            @(negedge core_clk);
            k++;
        end
        check("response", 16'h0001, {15'h0000, rsp_valid});
        got = rsp_rdata;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================
    // pin monitor
    always @(negedge core_clk) begin
        if (ready_busy_pin === 1'b1 && mode_sel == chs_mem_type_mode_mem)
            in_init <= 1'b0;
        if (reset)
            in_init <= 1'b1;
        if (!reset && (output_enable_n & write_enable_n & io_read_strobe_n
                       & io_write_strobe_n) !== 1'b1) begin
            check("access in init", 16'h0000, {15'h0000, in_init});
            if (mode_sel == chs_mem_type_mode_mem)
                check("io strobes", 16'h0003, {14'h0000, io_write_strobe_n, io_read_strobe_n});
            else if (mode_sel == chs_mem_type_mode_ide) begin
                check("ide attr select", 16'h0001, {15'h0000, attr_select_n});
                check("ide mode select", 16'h0000, {15'h0000, output_enable_n});
            end else if (!(io_write_strobe_n & io_read_strobe_n))
                check("io attr select", 16'h0000, {15'h0000, attr_select_n});
        end
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        check("ready after reset", 16'h0000, {15'h0000, card_ready});
        k = 0;
        while (req_ready !== 1'b1 && k < 300) begin
            @(negedge core_clk);
            k++;
        end
        check("init wait", 16'h0001, {15'h0000, k >= INIT_CYC - 1});
        check("ready offered", 16'h0001, {15'h0000, req_ready});
        check("ready after init", 16'h0001, {15'h0000, card_ready});
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            m = chs_mode_type'(i % 3);
            r = rnd();
            a = r[15];
            ad = r[3:0];
            d = rnd();
            access(m, 1'b1, a, ad, d);
            exp_mem[space(m, a)][ad] = d;
            seen[space(m, a)][ad] = 1'b1;
            access(m, 1'b0, a, ad, 16'h0000);
            check("read back", d, got);
        end
        $display("test write and read back done");
        // cross-mode reads find aliasing between spaces
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            m = chs_mode_type'(r[5:4] % 3);
            a = r[6];
            ad = r[3:0];
            if (seen[space(m, a)][ad]) begin
                access(m, 1'b0, a, ad, 16'h0000);
                check("random read", exp_mem[space(m, a)][ad], got);
            end
        end
        $display("test random reads done");
        for (int i = 0; i < 4; i++) begin
            mode_sel = (i < 2) ? chs_mem_type_mode_io : chs_mem_type_mode_ide;
            repeat (4) @(negedge core_clk);
            k = 0;
            irq_cmd = 1'b1;
            for (int c = 0; c < 16; c++) begin
                if (c == ((i % 2) ? 12 : 3))
                    irq_cmd = 1'b0;
                @(negedge core_clk);
                if (irq_event === 1'b1)
                    k++;
            end
            check("irq events", 16'h0001, k[15:0]);
            check("irq mode", {14'h0000, mode_sel}, {14'h0000, irq_last});
        end
        $display("test interrupts done");
        finish_test();
    end

    // ==========================================
    // watchdog, ample for some 2000 cycles of tests
    initial begin
        #200000;
        n_errors++;
        $display("watchdog expired");
        finish_test();
    end
endmodule
